// *** rtl/mrb_pkg.sv ***
// Purpose: shared constants for the mode register and burst order block
// Assumes: one 50 MHz core clock
// Notes: mode register addresses are the ones seen by mode register commands

package mrb_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	// init calibration time, plain default
	localparam int ZQ_INIT_NS = 1000;
	// longest time, rounded down, never below one cycle
	localparam int ZQ_INIT_CYC_RAW = ZQ_INIT_NS / CLK_PERIOD_NS;
	localparam int ZQ_INIT_CYC = (ZQ_INIT_CYC_RAW < 1) ? 1 : ZQ_INIT_CYC_RAW;

	// ---------------------------------------------------------------
	// mode register addresses and commands
	// ---------------------------------------------------------------
	localparam logic [7:0] MR_INFO_ADDR = 8'h00;
	localparam logic [7:0] MR_SETUP_ADDR = 8'h01;
	localparam logic [7:0] MR_CAL_ADDR = 8'h0A;
	localparam logic [7:0] CAL_INIT_CODE = 8'hFF;
	localparam logic [7:0] CAL_LONG_CODE = 8'hAB;
	localparam logic [7:0] CAL_SHORT_CODE = 8'h56;
	localparam logic [7:0] CAL_RESET_CODE = 8'hC3;

	// ---------------------------------------------------------------
	// device_information fields
	// ---------------------------------------------------------------
	localparam int INIT_BIT = 0;
	localparam int KIND_BIT = 1;
	localparam int DNV_BIT = 2;
	localparam int ZQ_LO = 3;
	localparam logic KIND_SDRAM = 1'h0;
	localparam logic DNV_UNSUPPORTED = 1'h0;
	localparam logic [1:0] ZQ_NONE = 2'h0;
	localparam logic [1:0] ZQ_SUPPLY = 2'h1;
	localparam logic [1:0] ZQ_GND = 2'h2;
	localparam logic [1:0] ZQ_PASS = 2'h3;

	// ---------------------------------------------------------------
	// burst_and_recovery_setup fields
	// ---------------------------------------------------------------
	localparam int BL_LO = 0;
	localparam int BT_BIT = 3;
	localparam int WC_BIT = 4;
	localparam int WR_LO = 5;
	localparam logic [2:0] BL4 = 3'h2;
	localparam logic [2:0] BL8 = 3'h3;
	localparam logic [2:0] BL16 = 3'h4;
	localparam logic [2:0] WR_MIN = 3'h1;
	localparam logic [2:0] WR_MAX = 3'h6;
	// recovery cycles are the code plus this offset
	localparam logic [3:0] WR_OFFSET = 4'h2;
	localparam logic [7:0] SETUP_RESET = 8'h22;

	// ---------------------------------------------------------------
	// burst sequencer states, gray along idle, run, recover
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN = 2'h1,
		ST_RECOV = 2'h3
	} mrb_state_type;

endpackage

// *** rtl/mrb_cycle_timer.sv ***
// Purpose: loadable down counter with a one-cycle done pulse
// Assumes: load wins over an ongoing count
// Notes: used for calibration time and write recovery

`timescale 1ns/100ps
`default_nettype none

module mrb_cycle_timer #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] cycles,
	output logic busy,
	output logic done
);

	logic [W-1:0] cnt_q, cnt_d;
	logic done_q, done_d;

	// count down to zero, pulse done on the last step
	always_comb begin
		cnt_d = cnt_q;
		done_d = 1'b0;
		if (load) begin
			cnt_d = cycles;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
			done_d = (cnt_q == W'(1));
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign busy = (cnt_q != '0);
	assign done = done_q;

endmodule // mrb_cycle_timer

`default_nettype wire

// *** rtl/mrb_burst_order.sv ***
// Purpose: column of one beat from start column, beat index and mode
// Assumes: caller only asks for legal combinations
// Notes: purely combinational

`timescale 1ns/100ps
`default_nettype none

module mrb_burst_order (
	input wire logic [2:0] bl_code,
	input wire logic interleave,
	input wire logic no_wrap,
	input wire logic [8:0] start_col,
	input wire logic [3:0] beat,
	output logic [8:0] col
);

	logic [8:0] mask;
	logic [8:0] seq_col;
	logic [8:0] int_col;

	// wrap window from burst length
	always_comb begin
		unique case (bl_code)
			mrb_pkg::BL8: mask = 9'h007;
			mrb_pkg::BL16: mask = 9'h00F;
			default: mask = 9'h003;
		endcase
	end

	// low bits wrap inside the window, high bits stay put
	assign seq_col = ((start_col + {5'h00, beat}) & mask) | (start_col & ~mask);
	assign int_col = ((start_col ^ {5'h00, beat}) & mask) | (start_col & ~mask);

	// four beats use the sequential form whatever the type
	always_comb begin
		if (no_wrap) begin
			col = start_col + {5'h00, beat};
		end else if (interleave && bl_code == mrb_pkg::BL8) begin
			col = int_col;
		end else begin
			col = seq_col;
		end
	end

endmodule // mrb_burst_order

`default_nettype wire

// *** rtl/mrb_mode_burst.sv ***
// Purpose: information and burst setup mode registers, burst column order,
//          write recovery before auto precharge, zq self-test reporting
// Assumes: mode register commands and burst requests arrive as
//          one-cycle strobes synchronous to core_clk
// Notes: register reads answer one cycle after the request

`timescale 1ns/100ps
`default_nettype none

module mrb_mode_burst #(
	parameter bit ZQ_TEST_SUPPORTED = 1'b1,
	parameter int ZQ_INIT_CYCLES = mrb_pkg::ZQ_INIT_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic init_running,
	input wire logic zq_sense_supply,
	input wire logic zq_sense_gnd,
	input wire logic mode_reg_write_cmd,
	input wire logic mode_reg_read_cmd,
	input wire logic [7:0] mode_reg_addr,
	input wire logic [7:0] mode_reg_wdata,
	output logic [7:0] mode_reg_rdata,
	output logic mode_reg_rvalid,
	output logic zq_cal_start,
	output logic [7:0] zq_cal_code,
	output logic factory_trim_sel,
	input wire logic burst_req,
	input wire logic burst_is_write,
	input wire logic auto_precharge_flag,
	input wire logic [8:0] burst_col,
	output logic burst_busy,
	output logic burst_refused,
	output logic beat_valid,
	output logic beat_last,
	output logic [8:0] beat_col,
	output logic precharge_start,
	output logic [2:0] burst_length_field,
	output logic [2:0] write_recovery_cycles
);

	// ---------------------------------------------------------------
	// state declarations
	// ---------------------------------------------------------------
	logic [7:0] setup_q, setup_d;
	logic init_q, init_d;
	logic [1:0] zq_q, zq_d;
	logic trim_q, trim_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic cal_start_q, cal_start_d;
	logic [7:0] cal_code_q, cal_code_d;
	logic cal_pending_q, cal_pending_d;

	mrb_pkg::mrb_state_type st_q, st_d;
	logic [3:0] beat_q, beat_d;
	logic [3:0] last_idx_q, last_idx_d;
	logic [8:0] start_q, start_d;
	logic [2:0] bl_q, bl_d;
	logic bt_q, bt_d;
	logic wc_q, wc_d;
	logic wr_q, wr_d;
	logic ap_q, ap_d;
	logic [3:0] nwr_q, nwr_d;
	logic refused_q, refused_d;
	logic bvalid_q, bvalid_d;
	logic blast_q, blast_d;
	logic [8:0] bcol_q, bcol_d;
	logic pre_q, pre_d;

	// ---------------------------------------------------------------
	// decoded fields of the setup register
	// ---------------------------------------------------------------
	logic [2:0] set_bl;
	logic set_bt;
	logic set_wc;
	logic [2:0] set_wr;
	logic [2:0] new_bl;
	logic [2:0] new_wr;
	logic setup_wr;
	logic cal_wr;
	logic cal_code_ok;
	logic cal_done;
	logic cal_busy;
	logic rec_done;
	logic rec_load;
	logic [8:0] order_col;
	logic [7:0] info_word;
	logic combo_bad;

	assign set_bl = setup_q[mrb_pkg::BL_LO +: 3];
	assign set_bt = setup_q[mrb_pkg::BT_BIT];
	assign set_wc = setup_q[mrb_pkg::WC_BIT];
	assign set_wr = setup_q[mrb_pkg::WR_LO +: 3];
	assign new_bl = mode_reg_wdata[mrb_pkg::BL_LO +: 3];
	assign new_wr = mode_reg_wdata[mrb_pkg::WR_LO +: 3];
	assign setup_wr = mode_reg_write_cmd && mode_reg_addr == mrb_pkg::MR_SETUP_ADDR;
	assign cal_wr = mode_reg_write_cmd && mode_reg_addr == mrb_pkg::MR_CAL_ADDR;

	// reserved calibration codes are dropped like faulted ones
	assign cal_code_ok = mode_reg_wdata == mrb_pkg::CAL_INIT_CODE
		|| mode_reg_wdata == mrb_pkg::CAL_LONG_CODE
		|| mode_reg_wdata == mrb_pkg::CAL_SHORT_CODE
		|| mode_reg_wdata == mrb_pkg::CAL_RESET_CODE;

	// ---------------------------------------------------------------
	// information word as seen by a mode register read
	// ---------------------------------------------------------------
	always_comb begin
		info_word = 8'h00; // reserved bits read zero
		info_word[mrb_pkg::INIT_BIT] = init_q;
		info_word[mrb_pkg::KIND_BIT] = mrb_pkg::KIND_SDRAM;
		info_word[mrb_pkg::DNV_BIT] = mrb_pkg::DNV_UNSUPPORTED;
		info_word[mrb_pkg::ZQ_LO +: 2] = zq_q;
	end

	// ---------------------------------------------------------------
	// mode register file and zq calibration
	// ---------------------------------------------------------------
	// illegal length or recovery codes keep the old field, so a bad
	// write cannot leave the burst logic with an undefined length
	always_comb begin
		setup_d = setup_q;
		init_d = init_running;
		zq_d = zq_q;
		trim_d = trim_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		cal_start_d = 1'b0;
		cal_code_d = cal_code_q;
		cal_pending_d = cal_pending_q;
		if (setup_wr) begin
			if (new_bl == mrb_pkg::BL4 || new_bl == mrb_pkg::BL8 || new_bl == mrb_pkg::BL16) begin
				setup_d[mrb_pkg::BL_LO +: 3] = new_bl;
			end
			if (new_wr >= mrb_pkg::WR_MIN && new_wr <= mrb_pkg::WR_MAX) begin
				setup_d[mrb_pkg::WR_LO +: 3] = new_wr;
			end
			setup_d[mrb_pkg::BT_BIT] = mode_reg_wdata[mrb_pkg::BT_BIT];
			setup_d[mrb_pkg::WC_BIT] = mode_reg_wdata[mrb_pkg::WC_BIT];
		end
		// a write to the information address falls through untouched
		// the start and done cycles count as busy, so a command there cannot lose its pending result
		if (cal_wr && cal_code_ok && !trim_q && !cal_busy && !cal_start_q && !cal_done) begin
			cal_start_d = 1'b1; // faulted zq ignores calibration
			cal_code_d = mode_reg_wdata;
			cal_pending_d = ZQ_TEST_SUPPORTED && mode_reg_wdata == mrb_pkg::CAL_INIT_CODE;
		end
		if (cal_done && cal_pending_q) begin
			cal_pending_d = 1'b0;
			// result only moves at the end of init calibration
			if (zq_sense_supply) begin
				zq_d = mrb_pkg::ZQ_SUPPLY;
			end else if (zq_sense_gnd) begin
				zq_d = mrb_pkg::ZQ_GND;
			end else begin
				zq_d = mrb_pkg::ZQ_PASS;
			end
			trim_d = zq_sense_supply || zq_sense_gnd;
		end
		if (mode_reg_read_cmd) begin
			rvalid_d = 1'b1;
			// write-only and unused addresses answer zero
			rdata_d = (mode_reg_addr == mrb_pkg::MR_INFO_ADDR) ? info_word : 8'h00;
		end
	end

	// defaults come back on every reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_q <= mrb_pkg::SETUP_RESET;
			init_q <= 1'b1;
			zq_q <= mrb_pkg::ZQ_NONE;
			trim_q <= 1'b0;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			cal_start_q <= 1'b0;
			cal_code_q <= 8'h00;
			cal_pending_q <= 1'b0;
		end else begin
			setup_q <= setup_d;
			init_q <= init_d;
			zq_q <= zq_d;
			trim_q <= trim_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			cal_start_q <= cal_start_d;
			cal_code_q <= cal_code_d;
			cal_pending_q <= cal_pending_d;
		end
	end

	// calibration time, restarted by each accepted calibration
	mrb_cycle_timer #(
		.W(16)
	) u_cal_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.load(cal_start_q),
		.cycles(16'(ZQ_INIT_CYCLES)),
		.busy(cal_busy),
		.done(cal_done)
	);

	// ---------------------------------------------------------------
	// burst sequencer
	// ---------------------------------------------------------------
	// unsupported combinations are refused at the start
	always_comb begin
		combo_bad = 1'b0;
		if (set_wc && set_bl != mrb_pkg::BL4) begin
			combo_bad = 1'b1;
		end
		if (set_bt && set_bl == mrb_pkg::BL16) begin
			combo_bad = 1'b1;
		end
	end

	mrb_burst_order u_order (
		.bl_code(bl_q),
		.interleave(bt_q),
		.no_wrap(wc_q),
		.start_col(start_q),
		.beat(beat_q),
		.col(order_col)
	);

	assign rec_load = blast_q && wr_q && ap_q;

	// settings are captured at the start, so a setup write lands
	// on the next burst and never mid-burst
	always_comb begin
		st_d = st_q;
		beat_d = beat_q;
		last_idx_d = last_idx_q;
		start_d = start_q;
		bl_d = bl_q;
		bt_d = bt_q;
		wc_d = wc_q;
		wr_d = wr_q;
		ap_d = ap_q;
		nwr_d = nwr_q;
		refused_d = 1'b0;
		bvalid_d = 1'b0;
		blast_d = 1'b0;
		bcol_d = bcol_q;
		pre_d = rec_done;
		unique case (st_q)
			mrb_pkg::ST_IDLE: begin
				if (burst_req && combo_bad) begin
					refused_d = 1'b1;
				end else if (burst_req) begin
					st_d = mrb_pkg::ST_RUN;
					beat_d = 4'h0;
					start_d = {burst_col[8:1], 1'b0};
					bl_d = set_bl;
					bt_d = set_bt;
					wc_d = set_wc;
					wr_d = burst_is_write;
					ap_d = auto_precharge_flag;
					nwr_d = {1'b0, set_wr} + mrb_pkg::WR_OFFSET;
					unique case (set_bl)
						mrb_pkg::BL8: last_idx_d = 4'h7;
						mrb_pkg::BL16: last_idx_d = 4'hF;
						default: last_idx_d = 4'h3;
					endcase
				end
			end
			mrb_pkg::ST_RUN: begin
				refused_d = burst_req;
				bvalid_d = 1'b1;
				bcol_d = order_col;
				beat_d = beat_q + 4'h1;
				if (beat_q == last_idx_q) begin
					blast_d = 1'b1;
					st_d = (wr_q && ap_q) ? mrb_pkg::ST_RECOV : mrb_pkg::ST_IDLE;
				end
			end
			mrb_pkg::ST_RECOV: begin
				// hold off new bursts until the bank precharge starts
				refused_d = burst_req;
				if (rec_done) begin
					st_d = mrb_pkg::ST_IDLE;
				end
			end
			default: begin
				st_d = mrb_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= mrb_pkg::ST_IDLE;
			beat_q <= 4'h0;
			last_idx_q <= 4'h3;
			start_q <= 9'h000;
			bl_q <= mrb_pkg::BL4;
			bt_q <= 1'b0;
			wc_q <= 1'b0;
			wr_q <= 1'b0;
			ap_q <= 1'b0;
			nwr_q <= 4'h3;
			refused_q <= 1'b0;
			bvalid_q <= 1'b0;
			blast_q <= 1'b0;
			bcol_q <= 9'h000;
			pre_q <= 1'b0;
		end else begin
			st_q <= st_d;
			beat_q <= beat_d;
			last_idx_q <= last_idx_d;
			start_q <= start_d;
			bl_q <= bl_d;
			bt_q <= bt_d;
			wc_q <= wc_d;
			wr_q <= wr_d;
			ap_q <= ap_d;
			nwr_q <= nwr_d;
			refused_q <= refused_d;
			bvalid_q <= bvalid_d;
			blast_q <= blast_d;
			bcol_q <= bcol_d;
			pre_q <= pre_d;
		end
	end

	// recovery counted from the cycle after the last beat
	mrb_cycle_timer #(
		.W(4)
	) u_rec_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.load(rec_load),
		.cycles(nwr_q),
		.busy(),
		.done(rec_done)
	);

	// ---------------------------------------------------------------
	// outputs, each from a flip-flop
	// ---------------------------------------------------------------
	assign mode_reg_rdata = rdata_q;
	assign mode_reg_rvalid = rvalid_q;
	assign zq_cal_start = cal_start_q;
	assign zq_cal_code = cal_code_q;
	assign factory_trim_sel = trim_q;
	assign burst_busy = st_q[0]; // run and recover share bit 0, so no decode
	assign burst_refused = refused_q;
	assign beat_valid = bvalid_q;
	assign beat_last = blast_q;
	assign beat_col = bcol_q;
	assign precharge_start = pre_q;
	assign burst_length_field = set_bl;
	assign write_recovery_cycles = set_wr;

endmodule // mrb_mode_burst

`default_nettype wire

// *** tb/mrb_mode_burst_sva.sv ***
// Purpose: port checker for mrb_mode_burst
// Assumes: bound to every mrb_mode_burst instance
// Notes: sees ports only, one clock domain
`timescale 1ns/100ps
`default_nettype none
module mrb_mode_burst_sva (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic init_running,
	input wire logic mode_reg_write_cmd,
	input wire logic mode_reg_read_cmd,
	input wire logic [7:0] mode_reg_addr,
	input wire logic [7:0] mode_reg_wdata,
	input wire logic [7:0] mode_reg_rdata,
	input wire logic zq_cal_start,
	input wire logic factory_trim_sel,
	input wire logic burst_req,
	input wire logic burst_busy,
	input wire logic burst_refused,
	input wire logic beat_valid,
	input wire logic beat_last,
	input wire logic [8:0] beat_col,
	input wire logic precharge_start,
	input wire logic [2:0] burst_length_field,
	input wire logic [2:0] write_recovery_cycles
);
	logic [3:0] gap_q;
	logic [3:0] gap_d;
	// cycles since the last beat, saturates so a long idle cannot alias
	always_comb begin
		gap_d = (gap_q == 4'hF) ? gap_q : gap_q + 4'h1;
		if (beat_last) gap_d = 4'h0;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) gap_q <= 4'hF;
		else gap_q <= gap_d;
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// info read request and an accepted four beat burst
	sequence s_info_rd;
		mode_reg_read_cmd && mode_reg_addr == 8'h00;
	endsequence
	sequence s_acc4;
		burst_req && !burst_busy && burst_length_field == 3'h2 ##1 !burst_refused;
	endsequence
	property p_init_bit;
		s_info_rd ##0 $stable(init_running) |=> mode_reg_rdata[0] == $past(init_running);
	endproperty
	a_init_bit: assert property (p_init_bit) else $error("init bit wrong");
	property p_info_fixed;
		s_info_rd |=> mode_reg_rdata[2:1] == 2'h0 && mode_reg_rdata[7:5] == 3'h0;
	endproperty
	a_info_fixed: assert property (p_info_fixed) else $error("fixed info bits set");
	property p_trim_block;
		mode_reg_write_cmd && mode_reg_addr == 8'h0A && factory_trim_sel |=> !zq_cal_start;
	endproperty
	a_trim_block: assert property (p_trim_block) else $error("calibration ran on trim");
	property p_bl_load;
		mode_reg_write_cmd && mode_reg_addr == 8'h01 |=> burst_length_field ==
			(($past(mode_reg_wdata[2:0]) inside {3'h2, 3'h3, 3'h4}) ?
			$past(mode_reg_wdata[2:0]) : $past(burst_length_field));
	endproperty
	a_bl_load: assert property (p_bl_load) else $error("length field wrong");
	property p_wr_load;
		mode_reg_write_cmd && mode_reg_addr == 8'h01 && mode_reg_wdata[7:5] inside {[3'h1:3'h6]}
			|=> write_recovery_cycles == $past(mode_reg_wdata[7:5]);
	endproperty
	a_wr_load: assert property (p_wr_load) else $error("recovery field wrong");
	property p_ro_write;
		mode_reg_write_cmd && mode_reg_addr == 8'h00 |=> $stable(burst_length_field) && $stable(write_recovery_cycles);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("info write had effect");
	property p_bl4_run;
		s_acc4 |-> ##1 beat_valid [*3] ##1 (beat_valid && beat_last);
	endproperty
	a_bl4_run: assert property (p_bl4_run) else $error("four beat burst wrong");
	property p_even;
		$rose(beat_valid) |-> !beat_col[0];
	endproperty
	a_even: assert property (p_even) else $error("burst began on odd column");
	property p_precharge;
		precharge_start |-> gap_q == {1'b0, write_recovery_cycles} + 4'h3;
	endproperty
	a_precharge: assert property (p_precharge) else $error("precharge at wrong time");
endmodule // mrb_mode_burst_sva
bind mrb_mode_burst mrb_mode_burst_sva u_sva (.*);
`default_nettype wire

// *** tb/mrb_host_model.sv ***
// Purpose: memory controller model for mode register and burst requests
// Assumes: requests change just after a rising edge
// Notes: released write data and column buses show the inverse of their last value, the address holds
`timescale 1ns/100ps
`default_nettype none
module mrb_host_model (
	input wire logic core_clk,
	input wire logic [7:0] mode_reg_rdata,
	input wire logic mode_reg_rvalid,
	output logic mode_reg_write_cmd,
	output logic mode_reg_read_cmd,
	output logic [7:0] mode_reg_addr,
	output logic [7:0] mode_reg_wdata,
	output logic burst_req,
	output logic burst_is_write,
	output logic auto_precharge_flag,
	output logic [8:0] burst_col
);
	// idle at time zero
	initial begin
		{mode_reg_write_cmd, mode_reg_read_cmd, burst_req, burst_is_write, auto_precharge_flag} = 5'h00;
		{mode_reg_addr, mode_reg_wdata} = 16'h0000;
		burst_col = 9'h000;
	end
	// one write, the caller keeps reserved positions at zero
	task automatic mr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		mode_reg_write_cmd <= 1'b1;
		mode_reg_addr <= a;
		mode_reg_wdata <= d;
		@(posedge core_clk);
		mode_reg_write_cmd <= 1'b0;
		mode_reg_wdata <= ~d;
	endtask
	// one read, answer taken one edge after the request
	task automatic mr_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge core_clk);
		mode_reg_read_cmd <= 1'b1;
		mode_reg_addr <= a;
		@(posedge core_clk);
		mode_reg_read_cmd <= 1'b0;
		#1;
		ok = mode_reg_rvalid;
		d = mode_reg_rdata;
	endtask
	// burst request, never a no-wrap start at 1FE, 1FF, 000 or 001
	task automatic burst(input logic w, input logic ap, input logic [8:0] c);
		@(posedge core_clk);
		burst_req <= 1'b1;
		burst_is_write <= w;
		auto_precharge_flag <= ap;
		burst_col <= c;
		@(posedge core_clk);
		burst_req <= 1'b0;
		burst_col <= ~c;
	endtask
endmodule // mrb_host_model
`default_nettype wire

// *** tb/mrb_mode_burst_tb.sv ***
// Purpose: self-checking bench for mrb_mode_burst
// Assumes: calibration shortened to 4 cycles
// Notes: expected columns are worked out here from the ordering table
`timescale 1ns/100ps
`default_nettype none
module mrb_mode_burst_tb;
	logic core_clk, rst_n, init_running, zq_sense_supply, zq_sense_gnd;
	logic mode_reg_write_cmd, mode_reg_read_cmd, mode_reg_rvalid, zq_cal_start, factory_trim_sel;
	logic [7:0] mode_reg_addr, mode_reg_wdata, mode_reg_rdata, zq_cal_code;
	logic burst_req, burst_is_write, auto_precharge_flag, burst_busy, burst_refused;
	logic beat_valid, beat_last, precharge_start;
	logic [8:0] burst_col, beat_col;
	logic [2:0] burst_length_field, write_recovery_cycles;
	int err_count = 0;
	int checked = 0;
	int j;
	int k;
	logic [14:0] cs;
	// length code, {interleave, no wrap, accepted}, start column
	localparam logic [14:0] CASES [9] = '{
		{3'h2, 3'h1, 9'h00A}, {3'h2, 3'h5, 9'h007}, {3'h2, 3'h3, 9'h0FE},
		{3'h3, 3'h1, 9'h1F6}, {3'h3, 3'h5, 9'h00B}, {3'h4, 3'h1, 9'h013},
		{3'h3, 3'h2, 9'h020}, {3'h4, 3'h2, 9'h020}, {3'h4, 3'h4, 9'h020}};
	mrb_host_model host (.*);
	mrb_mode_burst #(.ZQ_INIT_CYCLES(4)) dut (.*);
	// 50 MHz clock
	always #10 core_clk = ~core_clk;
	task automatic chk(input logic [8:0] seen, input logic [8:0] want);
		checked++;
		if (seen !== want) begin
			err_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic rd(input logic [7:0] want);
		logic [7:0] d;
		logic ok;
		host.mr_read(8'h00, d, ok);
		chk({ok, d}, {1'b1, want});
	endtask
	task automatic do_reset;
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
	endtask
	function automatic logic [8:0] exp_col(input logic [2:0] bl, input logic il, input logic nw,
		input logic [8:0] c, input logic [3:0] i);
		logic [8:0] s;
		s = {c[8:1], 1'b0};
		if (nw) return s + {5'h00, i};
		if (bl == 3'h2) return {s[8:2], s[1:0] + i[1:0]};
		if (bl == 3'h3) return {s[8:3], il ? s[2:0] ^ i[2:0] : s[2:0] + i[2:0]};
		return {s[8:4], s[3:0] + i};
	endfunction
	// waits a bounded time for the first beat, then checks every beat
	task automatic beats(input logic [2:0] bl, input logic il, input logic nw, input logic [8:0] c);
		int n;
		int i;
		n = (bl == 3'h2) ? 4 : (bl == 3'h3) ? 8 : 16;
		for (i = 0; i < 4 && beat_valid !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		for (i = 0; i < n; i++) begin
			chk(beat_col, exp_col(bl, il, nw, c, i[3:0]));
			chk({beat_valid, beat_last}, {1'b1, i == n - 1});
			@(posedge core_clk);
			#1;
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// watchdog, the tests need well under 3000 cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		$display("watchdog expired");
		print_verdict;
	end
	// main sequence
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		init_running = 1'b1;
		zq_sense_supply = 1'b0;
		zq_sense_gnd = 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		chk({write_recovery_cycles, burst_length_field}, 9'h00A);
		rd(8'h01);
		@(posedge core_clk);
		init_running <= 1'b0;
		repeat (2) @(posedge core_clk);
		rd(8'h00);
		host.mr_write(8'h00, 8'h1F);
		rd(8'h00);
		chk(burst_length_field, 3'h2);
		$display("test info_and_defaults done");
		host.mr_write(8'h0A, 8'hFF);
		#1;
		chk(zq_cal_start, 1'b1);
		chk(zq_cal_code, 8'hFF);
		rd(8'h00);
		repeat (12) @(posedge core_clk);
		rd(8'h18);
		chk(factory_trim_sel, 1'b0);
		host.mr_write(8'h0A, 8'hAB);
		#1;
		chk(zq_cal_start, 1'b1);
		chk(zq_cal_code, 8'hAB);
		repeat (12) @(posedge core_clk);
		rd(8'h18);
		// reserved calibration code must not start anything
		host.mr_write(8'h0A, 8'h5A);
		#1;
		chk(zq_cal_start, 1'b0);
		chk(zq_cal_code, 8'hAB);
		// fault straps: supply first, then ground
		for (j = 0; j < 2; j++) begin
			@(posedge core_clk);
			zq_sense_supply <= (j == 0);
			zq_sense_gnd <= (j == 1);
			do_reset;
			host.mr_write(8'h0A, 8'hFF);
			repeat (12) @(posedge core_clk);
			rd(j == 0 ? 8'h08 : 8'h10);
			chk(factory_trim_sel, 1'b1);
			host.mr_write(8'h0A, 8'hAB);
			#1;
			chk(zq_cal_start, 1'b0);
		end
		$display("test zq_selftest done");
		host.mr_write(8'h01, 8'hC3);
		#1;
		chk({write_recovery_cycles, burst_length_field}, 9'h033);
		host.mr_write(8'h01, 8'hE5);
		#1;
		chk({write_recovery_cycles, burst_length_field}, 9'h033);
		$display("test setup_codes done");
		for (j = 0; j < 9; j++) begin
			cs = CASES[j];
			host.mr_write(8'h01, {3'h1, cs[10], cs[11], cs[14:12]});
			host.burst(1'b0, 1'b0, cs[8:0]);
			#1;
			if (cs[9]) beats(cs[14:12], cs[11], cs[10], cs[8:0]);
			else chk(burst_refused, 1'b1);
		end
		$display("test burst_orders done");
		host.mr_write(8'h01, 8'hC2);
		host.burst(1'b1, 1'b1, 9'h040);
		#1;
		beats(3'h2, 1'b0, 1'b0, 9'h040);
		chk(burst_busy, 1'b1);
		for (k = 1; k < 20 && precharge_start !== 1'b1; k++) begin
			@(posedge core_clk);
			#1;
		end
		chk(k[8:0], 9'h00A);
		chk(burst_busy, 1'b0);
		$display("test write_recovery done");
		print_verdict;
	end
endmodule // mrb_mode_burst_tb
`default_nettype wire
